//--- rtl/cod_pkg.sv
// Constants, types and register map of the operand address decoder
// Operation
// [RULE1] Four 16-bit accumulators serve as working registers selected by instructions.
// [RULE2] Only the third and fourth accumulators may act as index registers.
// [RULE3] Program counter, address latch and data latch are hidden from instructions.
// [RULE4] Sixteen-entry last-in first-out stack of 16-bit words.
// [RULE5] Sixteen flags form one register; unassigned flags stay freely settable.
// [RULE6] All arithmetic is binary two's complement on 16-bit operands.
// [RULE7] Mode zero: address is the offset, unsigned 0 to 255.
// [RULE8] Mode one: address is program counter plus sign-extended offset.
// [RULE9] Modes two and three: index accumulator plus sign-extended offset.
// [RULE10] Register-select field chooses the accumulator that supplies or receives the operand.
// [RULE11] Register-to-register class reads the mode bits as a second accumulator.
// [RULE12] Single-register class has a six-bit operation field, accumulator from mode bits; the code loads accumulator zero into the data latch.
// [RULE13] Expanded memory-reference instructions take two words; second is 16-bit displacement.
// [RULE14] Expanded non-memory instructions are single words with no displacement.
// [RULE15] Basic set of 43 in one microcode store, expanded 17 in another.
// [RULE16] The I/O unit requests the bus and transfers only after grant.
// [RULE17] Bus transfers run independently of arithmetic and register activity.
// [RULE18] Bus control arbitrates all requesters and grants by priority.
// [RULE19] A grant lasts one bus cycle, only with no higher request pending.
// [RULE20] Offset in the low byte; mode, register and operation fields above.
// [RULE21] Operand address arithmetic wraps modulo 65536.
package cod_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ACC0 = 8'h00;
  localparam logic [7:0] OFF_ACC3 = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_INSTR = 8'h14;
  localparam logic [7:0] OFF_DISP = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_ADDR = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_STACK = 8'h28;
  localparam logic [7:0] OFF_PC = 8'h2C;
  localparam logic [7:0] OFF_DATA = 8'h30;
  localparam logic [7:0] OFF_IOREQ = 8'h34;
  // ----------------------------------------------------------------
  // Instruction field positions and set sizes
  // ----------------------------------------------------------------
  localparam int DISP_LSB = 0;
  localparam int MODE_LSB = 8;
  localparam int REG_LSB = 10;
  localparam int OP_LSB = 12;
  localparam int BASIC_COUNT = 43;
  localparam int EXP_COUNT = 17;
  localparam int STACK_DEPTH = 16;
  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {CLS_MEMREF, CLS_REGREG, CLS_SINGLE, CLS_MISC} cod_cls_t;
  typedef struct packed {
    cod_cls_t cls;
    logic [5:0] opField;
    logic [1:0] regSel;
    logic [1:0] modeSel;
    logic [7:0] disp;
  } cod_dec_t;
endpackage : cod_pkg

//--- rtl/cod_decoder.sv
// Operand address decoder with register file, stack, flags and bus arbiter
module cod_decoder import cod_pkg::*; #(
  parameter int NREQ = 4 // External bus requesters
) (
  input wire logic mclk, // 125 MHz clock
  input wire logic rst_b, // Synchronous reset, low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [NREQ-1:0] busReqExt, // Other bus requesters
  output logic [NREQ-1:0] busGrantExt, // Their one-cycle grants
  output logic sysStrobe, // Own bus cycle
  output logic sysWrite, // Own cycle is a write
  output logic [15:0] sysAddr, // Own cycle address
  output logic [15:0] sysWdata, // Own cycle write data
  input wire logic [15:0] sysRdata // Read data during own cycle
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] acc [4];
  logic [15:0] next_acc [4];
  logic [15:0] flags, next_flags;
  logic [15:0] pc, next_pc;
  logic [15:0] memAddrLatch, next_memAddrLatch;
  logic [15:0] memDataLatch, next_memDataLatch;
  cod_dec_t dec, next_dec;
  logic [5:0] entry, next_entry;
  logic expSel, next_expSel;
  logic waitDisp, next_waitDisp;
  logic illegal, next_illegal;
  logic [15:0] stackMem [STACK_DEPTH];
  logic [4:0] depth, next_depth;
  logic push, pop;
  logic [15:0] pushData;
  logic ioReq, next_ioReq, ioWrite, next_ioWrite;
  logic [NREQ:0] grantQ, next_grant;
  logic next_sysStrobe, next_sysWrite;
  logic [15:0] next_sysAddr, next_sysWdata;
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0] awAddrQ, next_awAddrQ;
  logic [31:0] wDataQ, next_wDataQ;
  logic [3:0] wStrbQ, next_wStrbQ;
  logic bvalidQ, next_bvalid, rvalidQ, next_rvalid;
  logic [1:0] brespQ, next_bresp, rrespQ, next_rresp;
  logic [31:0] rdataQ, next_rdata;
  logic doWrite, doRead, instrWr;
  logic [15:0] wordQ;
  logic [NREQ:0] reqVec;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge for the 16-bit registers; upper lanes are ignored
  function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction : mergeBytes

  // Wrapping two's-complement address former, shared by both sets
  function automatic logic [15:0] formAddr(input logic [1:0] mode, input logic [15:0] d,
                                           input logic [15:0] p, input logic [15:0] ix2,
                                           input logic [15:0] ix3);
    logic [15:0] r;
    unique case (mode)
      2'd0: r = d; // RULE7
      2'd1: r = 16'(p + d); // RULE8 RULE6 RULE21
      2'd2: r = 16'(ix2 + d); // RULE9 RULE2 RULE21
      2'd3: r = 16'(ix3 + d); // RULE9 RULE2 RULE21
    endcase
    return r;
  endfunction : formAddr

  // Field split and class of one instruction word
  function automatic cod_dec_t splitWord(input logic [15:0] w);
    cod_dec_t r;
    r.disp = w[DISP_LSB +: 8]; // RULE20
    r.modeSel = w[MODE_LSB +: 2]; // RULE20
    r.regSel = w[REG_LSB +: 2]; // RULE20
    r.opField = {2'b00, w[OP_LSB +: 4]};
    if (w[OP_LSB +: 4] != 4'h0) begin
      r.cls = CLS_MEMREF;
    end else if (w[REG_LSB +: 2] == 2'b00) begin
      r.cls = CLS_SINGLE; // RULE12
      r.opField = w[REG_LSB +: 6]; // RULE12
    end else if (w[REG_LSB +: 2] == 2'b01) begin
      r.cls = CLS_REGREG; // RULE11
    end else begin
      r.cls = CLS_MISC;
    end
    return r;
  endfunction : splitWord

  // Microcode entry in the selected store; out of range marks illegal
  function automatic logic [6:0] storeEntry(input logic [15:0] w, input logic ex);
    logic [5:0] e;
    logic bad;
    e = ex ? {1'b0, w[15:11]} : w[15:10];
    bad = ex ? (e >= 6'(EXP_COUNT)) : (e >= 6'(BASIC_COUNT)); // RULE15
    return {bad, e};
  endfunction : storeEntry

  // ----------------------------------------------------------------
  // Bus slave handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHeld && !bvalidQ;
  assign s_axi_wready = !wHeld && !bvalidQ;
  assign s_axi_arready = !rvalidQ;
  assign s_axi_bvalid = bvalidQ;
  assign s_axi_bresp = brespQ;
  assign s_axi_rvalid = rvalidQ;
  assign s_axi_rresp = rrespQ;
  assign s_axi_rdata = rdataQ;
  assign doWrite = awHeld && wHeld && !bvalidQ;
  assign doRead = s_axi_arvalid && !rvalidQ;
  assign wordQ = wDataQ[15:0];
  assign instrWr = doWrite && (awAddrQ == OFF_INSTR);
  assign busGrantExt = grantQ[NREQ:1];
  assign reqVec = {busReqExt, ioReq};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus cycles use their own latches so a pending transfer never holds
  // up decode or accumulator updates
  always_comb begin
    cod_dec_t d;
    logic [6:0] ent;
    logic [15:0] dispX;
    logic found;
    d = splitWord(wordQ);
    ent = storeEntry(wordQ, expSel);
    dispX = 16'h0000;
    found = 1'b0;
    for (int i = 0; i < 4; i++) next_acc[i] = acc[i];
    next_flags = flags;
    next_pc = pc;
    next_memAddrLatch = memAddrLatch;
    next_memDataLatch = memDataLatch;
    next_dec = dec;
    next_entry = entry;
    next_expSel = expSel;
    next_waitDisp = waitDisp;
    next_illegal = illegal;
    next_depth = depth;
    push = 1'b0;
    pop = 1'b0;
    pushData = wordQ;
    next_ioReq = ioReq;
    next_ioWrite = ioWrite;
    next_awHeld = awHeld;
    next_awAddrQ = awAddrQ;
    next_wHeld = wHeld;
    next_wDataQ = wDataQ;
    next_wStrbQ = wStrbQ;
    next_bvalid = bvalidQ;
    next_bresp = brespQ;
    next_rvalid = rvalidQ;
    next_rresp = rrespQ;
    next_rdata = rdataQ;
    // Arbiter: lowest index wins, each grant lasts one cycle
    next_grant = '0;
    for (int i = 0; i <= NREQ; i++) begin
      if (reqVec[i] && !found) begin
        next_grant[i] = 1'b1; // RULE18 RULE19
        found = 1'b1;
      end
    end
    next_sysStrobe = next_grant[0]; // RULE16
    next_sysWrite = ioWrite;
    next_sysAddr = memAddrLatch;
    next_sysWdata = memDataLatch;
    if (next_grant[0]) next_ioReq = 1'b0;
    // Read data of an own cycle returns to the data latch
    if (sysStrobe && !sysWrite) next_memDataLatch = sysRdata; // RULE17
    // Write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddrQ = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wDataQ = s_axi_wdata;
      next_wStrbQ = s_axi_wstrb;
    end
    if (bvalidQ && s_axi_bready) next_bvalid = 1'b0;
    if (rvalidQ && s_axi_rready) next_rvalid = 1'b0;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (awAddrQ <= OFF_ACC3 && awAddrQ[1:0] == 2'b00) begin
        next_acc[awAddrQ[3:2]] = mergeBytes(acc[awAddrQ[3:2]], wDataQ, wStrbQ); // RULE1
      end else if (awAddrQ == OFF_FLAGS) begin
        next_flags = mergeBytes(flags, wDataQ, wStrbQ); // RULE5
      end else if (awAddrQ == OFF_INSTR) begin
        // Whole word only; the instruction pointer moves past it
        next_dec = d;
        next_entry = ent[5:0];
        next_illegal = ent[6];
        next_pc = 16'(pc + 16'h0001); // RULE21
        next_memDataLatch = acc[d.regSel]; // RULE10
        if (d.cls == CLS_MEMREF && expSel) begin
          next_waitDisp = 1'b1; // RULE13
        end else begin
          next_waitDisp = 1'b0; // RULE14
          if (d.cls == CLS_MEMREF) begin
            dispX = (d.modeSel == 2'd0) ? {8'h00, d.disp} : {{8{d.disp[7]}}, d.disp};
            next_memAddrLatch = formAddr(d.modeSel, dispX, pc, acc[2], acc[3]); // RULE7
          end
        end
      end else if (awAddrQ == OFF_DISP) begin
        // Second word only counts while one is awaited
        if (waitDisp) begin
          next_waitDisp = 1'b0;
          next_pc = 16'(pc + 16'h0001);
          next_memAddrLatch = formAddr(dec.modeSel, wordQ, pc, acc[2], acc[3]); // RULE13
        end
      end else if (awAddrQ == OFF_CTRL) begin
        if (wStrbQ[0]) next_expSel = wDataQ[0];
      end else if (awAddrQ == OFF_STACK) begin
        push = 1'b1; // RULE4
      end else if (awAddrQ == OFF_IOREQ) begin
        if (wStrbQ[0] && wDataQ[0]) begin
          next_ioReq = 1'b1; // RULE16
          next_ioWrite = wDataQ[1];
        end
      end else if (awAddrQ == OFF_PC || awAddrQ == OFF_ADDR || awAddrQ == OFF_DATA ||
                   awAddrQ == OFF_STATUS) begin
        next_bresp = RESP_OKAY; // RULE3
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (doRead) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr <= OFF_ACC3 && s_axi_araddr[1:0] == 2'b00) begin
        next_rdata[15:0] = acc[s_axi_araddr[3:2]];
      end else begin
        unique case (s_axi_araddr)
          OFF_FLAGS: next_rdata[15:0] = flags;
          OFF_CTRL: next_rdata[0] = expSel;
          OFF_ADDR: next_rdata[15:0] = memAddrLatch;
          OFF_PC: next_rdata[15:0] = pc;
          OFF_DATA: next_rdata[15:0] = memDataLatch;
          OFF_IOREQ: next_rdata[1:0] = {ioWrite, ioReq};
          OFF_STATUS: next_rdata = {11'h000, depth, 2'b00, illegal, waitDisp, dec.modeSel,
                                    dec.regSel, dec.cls, entry};
          OFF_STACK: begin
            if (depth != 5'd0) begin
              next_rdata[15:0] = stackMem[4'(depth - 5'd1)];
              pop = 1'b1; // RULE4
            end
          end
          OFF_INSTR, OFF_DISP: next_rdata = 32'h0000_0000;
          default: next_rresp = RESP_SLVERR;
        endcase
      end
    end
    // Push on a full stack is dropped; a pop and push together swap the top
    if (push && pop) begin
      next_depth = depth;
    end else if (push && depth != 5'(STACK_DEPTH)) begin
      next_depth = 5'(depth + 5'd1);
    end else if (pop) begin
      next_depth = 5'(depth - 5'd1);
    end else begin
      push = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) acc[i] <= RST_WORD;
      flags <= RST_WORD;
      pc <= RST_WORD;
      memAddrLatch <= RST_WORD;
      memDataLatch <= RST_WORD;
      dec <= '0;
      entry <= '0;
      expSel <= 1'b0;
      waitDisp <= 1'b0;
      illegal <= 1'b0;
      depth <= '0;
      ioReq <= 1'b0;
      ioWrite <= 1'b0;
      grantQ <= '0;
      sysStrobe <= 1'b0;
      sysWrite <= 1'b0;
      sysAddr <= RST_WORD;
      sysWdata <= RST_WORD;
      awHeld <= 1'b0;
      awAddrQ <= '0;
      wHeld <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= '0;
      bvalidQ <= 1'b0;
      brespQ <= RESP_OKAY;
      rvalidQ <= 1'b0;
      rrespQ <= RESP_OKAY;
      rdataQ <= '0;
    end else begin
      for (int i = 0; i < 4; i++) acc[i] <= next_acc[i];
      flags <= next_flags;
      pc <= next_pc;
      memAddrLatch <= next_memAddrLatch;
      memDataLatch <= next_memDataLatch;
      dec <= next_dec;
      entry <= next_entry;
      expSel <= next_expSel;
      waitDisp <= next_waitDisp;
      illegal <= next_illegal;
      depth <= next_depth;
      ioReq <= next_ioReq;
      ioWrite <= next_ioWrite;
      grantQ <= next_grant;
      sysStrobe <= next_sysStrobe;
      sysWrite <= next_sysWrite;
      sysAddr <= next_sysAddr;
      sysWdata <= next_sysWdata;
      awHeld <= next_awHeld;
      awAddrQ <= next_awAddrQ;
      wHeld <= next_wHeld;
      wDataQ <= next_wDataQ;
      wStrbQ <= next_wStrbQ;
      bvalidQ <= next_bvalid;
      brespQ <= next_bresp;
      rvalidQ <= next_rvalid;
      rrespQ <= next_rresp;
      rdataQ <= next_rdata;
    end
  end

  // Stack storage; no reset needed, depth guards every read
  always_ff @(posedge mclk) begin
    if (push) stackMem[4'(pop ? depth - 5'd1 : depth)] <= pushData; // RULE4
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  grant_onehot_a: assert property ($onehot0(grantQ)) // RULE18
    else $error("more than one bus grant");
  grant_priority_a: assert property (grantQ[1] |-> !$past(ioReq)) // RULE19
    else $error("lower requester granted over pending own request");
  // A new request written at the grant edge may leave the flag set again
  io_after_grant_a: assert property (sysStrobe |-> grantQ[0] && (!ioReq || $past(doWrite))) // RULE16
    else $error("own bus cycle without grant");
  base_page_a: assert property (instrWr && !expSel && wordQ[15:12] != 4'h0 &&
      wordQ[9:8] == 2'd0 |=> memAddrLatch == {8'h00, $past(wordQ[7:0])}) // RULE7
    else $error("base page address wrong");
  relative_a: assert property (instrWr && !expSel && wordQ[15:12] != 4'h0 &&
      wordQ[9:8] == 2'd1 |=> memAddrLatch ==
      16'($past(pc) + {{8{$past(wordQ[7])}}, $past(wordQ[7:0])})) // RULE8
    else $error("relative address wrong");
  index_three_a: assert property (instrWr && !expSel && wordQ[15:12] != 4'h0 &&
      wordQ[9:8] == 2'd3 |=> memAddrLatch ==
      16'($past(acc[3]) + {{8{$past(wordQ[7])}}, $past(wordQ[7:0])})) // RULE9
    else $error("indexed address wrong");
  operand_reg_a: assert property (instrWr |=> memDataLatch == $past(acc[wordQ[11:10]])) // RULE10
    else $error("operand register not selected");
  exp_two_word_a: assert property (instrWr && expSel && wordQ[15:12] != 4'h0
      |=> waitDisp ##1 memAddrLatch == $past(memAddrLatch, 2) || !waitDisp) // RULE13
    else $error("expanded memory word not awaiting displacement");
  exp_one_word_a: assert property (instrWr && expSel && wordQ[15:12] == 4'h0
      |=> !waitDisp) // RULE14
    else $error("expanded non-memory word waits for displacement");
  stack_bound_a: assert property (depth <= 5'(STACK_DEPTH)) // RULE4
    else $error("stack depth beyond sixteen");
  write_answer_a: assert property (doWrite |=> s_axi_bvalid) // RULE1
    else $error("write answer missing");

  io_cycle_c: cover property (ioReq ##[1:4] sysStrobe);
  exp_pair_c: cover property (instrWr && expSel ##[1:20] !waitDisp);
  stack_full_c: cover property (depth == 5'(STACK_DEPTH));
  contend_c: cover property (ioReq && busReqExt[0]);
endmodule : cod_decoder

//--- dv/cod_sys_mem.sv
// Memory model on the far side of the decoder's own system bus
module cod_sys_mem import cod_pkg::*; (
  input wire logic mclk, // Processor clock
  input wire logic sysStrobe, // Own bus cycle
  input wire logic sysWrite, // Cycle is a write
  input wire logic [15:0] sysAddr, // Cycle address
  input wire logic [15:0] sysWdata, // Write data
  output logic [15:0] sysRdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  logic [15:0] lastVal = 16'h0000;
  // Drive only in a read cycle; a released bus shows the inverse, never a stale word
  assign sysRdata = (sysStrobe && !sysWrite) ? mem[sysAddr[7:0]] : ~lastVal;
  // Store writes, remember the last word read out over the bus
  always @(posedge mclk) begin
    if (sysStrobe && sysWrite) mem[sysAddr[7:0]] <= sysWdata;
    if (sysStrobe && !sysWrite) lastVal <= mem[sysAddr[7:0]];
  end
endmodule : cod_sys_mem

//--- dv/cpu_operand_address_decoder_bench.sv
// Self-checking bench for the operand address decoder
module cpu_operand_address_decoder_bench import cod_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, busReqExt = 4'h0, busGrantExt, prevReq = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, clsExp;
  logic sysStrobe, sysWrite, prevRst = 1'b0;
  logic [15:0] sysAddr, sysWdata, sysRdata, pcExp, w, e;
  logic [15:0] acc [4];
  logic [33:0] rdQ [$];
  logic [1:0] bQ [$];
  logic [31:0] seed = 32'hEDA6, rSeed = 32'hEDA6;
  logic [7:0] offs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
  logic [15:0] wt [5] = '{16'h0600, 16'h0300, 16'hA800, 16'hAC00, 16'h0B00};
  int mismatches = 0, checks = 0, cycles = 0, strobes = 0;

  cod_decoder #(.NREQ(4)) cod_decoder_inst (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busReqExt, .busGrantExt, .sysStrobe,
    .sysWrite, .sysAddr, .sysWdata, .sysRdata);
  cod_sys_mem cod_sys_mem_inst (.mclk, .sysStrobe, .sysWrite, .sysAddr, .sysWdata, .sysRdata);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Write: offer address and data together, drop each once taken, wait for the answer
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OKAY);
    bQ.push_back(r);
    seed = lfsr(seed);
    s_axi_awaddr <= a;
    s_axi_wdata <= {seed[15:0], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr
  // Read: note the expected word, then hold the address until taken
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    rdQ.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!(s_axi_rvalid && s_axi_rready));
  endtask : rd

  initial forever #4 mclk = ~mclk;
  // Cycle limit cuts a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // Answers against oldest notes; random read stalls and rival requesters; grant priority
  always @(posedge mclk) begin
    rSeed <= lfsr(rSeed);
    // Ready only changes while low or at a handshake, so a raised rready waits for rvalid
    if (!s_axi_rready || s_axi_rvalid) s_axi_rready <= rSeed[0] | rSeed[1];
    busReqExt <= rSeed[7:4] & {4{rSeed[9]}};
    prevReq <= busReqExt;
    prevRst <= rst_b;
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bQ.pop_front());
    // Own cycles: first writes accumulator zero, second reads back, both at base page 5A
    if (sysStrobe) begin
      check({sysWrite, sysAddr}, {strobes == 0, 16'h005A});
      if (sysWrite) check(sysWdata, acc[0]);
      strobes++;
    end
    if (prevRst && rst_b) check(busGrantExt, sysStrobe ? 4'h0 : prevReq & (~prevReq + 4'h1));
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge mclk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    // Accumulators and every flag bit hold random words; third one sits near the wrap
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      w = (i == 2) ? 16'hFFF0 : seed[15:0];
      if (i < 4) acc[i] = w;
      wr(8'(4 * i), w);
      rd(8'(4 * i), {16'h0, w});
    end
    wr(8'h38, 16'h5A5A, RESP_SLVERR);
    rd(8'h38, 32'h0, RESP_SLVERR);
    wr(OFF_PC, 16'h1234);
    rd(OFF_PC, 32'h0);
    pcExp = 16'h0000;
    // All registers and modes, random and extreme offsets
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      w = {4'h2, 2'(i >> 2), 2'(i), i[3] ? {i[2], {7{~i[2]}}} : seed[7:0]};
      case (w[9:8])
        2'h0: e = {8'h00, w[7:0]};
        2'h1: e = pcExp + {{8{w[7]}}, w[7:0]};
        default: e = acc[{1'b1, w[8]}] + {{8{w[7]}}, w[7:0]};
      endcase
      wr(OFF_INSTR, w);
      pcExp++;
      rd(OFF_ADDR, {16'h0, e});
      rd(OFF_DATA, {16'h0, acc[w[11:10]]});
      rd(OFF_STATUS, {20'h0, w[9:8], w[11:10], 2'h0, w[15:10]});
    end
    // Other classes and the entry limit of the basic store
    foreach (wt[i]) begin
      clsExp = (wt[i][15:12] != 4'h0) ? 2'h0 : (wt[i][11:10] == 2'h0) ? 2'h2 :
        (wt[i][11:10] == 2'h1) ? 2'h1 : 2'h3;
      wr(OFF_INSTR, wt[i]);
      pcExp++;
      rd(OFF_STATUS, {18'h0, wt[i][15:10] >= 6'h2B, 1'b0, wt[i][9:8], wt[i][11:10], clsExp,
        wt[i][15:10]});
    end
    // Expanded set: two two-word memory references, then a single word
    wr(OFF_CTRL, 16'h0001);
    wr(OFF_INSTR, 16'h1300);
    rd(OFF_STATUS, 32'h0000_1C02);
    wr(OFF_DISP, 16'h8001);
    rd(OFF_ADDR, {16'h0, acc[3] + 16'h8001});
    pcExp += 16'h0002;
    wr(OFF_INSTR, 16'h1100);
    wr(OFF_DISP, 16'hFFFE);
    rd(OFF_ADDR, {16'h0, pcExp + 16'hFFFF});
    pcExp += 16'h0002;
    wr(OFF_INSTR, 16'h0800);
    rd(OFF_STATUS, 32'h0000_02C1);
    rd(OFF_PC, {16'h0, pcExp + 16'h0001});
    wr(OFF_CTRL, 16'h0000);
    // Seventeenth push is dropped; pops come back last in first out
    for (int i = 0; i < 17; i++) wr(OFF_STACK, 16'h0100 + 16'(i));
    rd(OFF_STATUS, 32'h0010_02C1);
    for (int i = 0; i < 17; i++) rd(OFF_STACK, (i < 16) ? 32'h010F - 32'(i) : 32'h0);
    // Own bus write, then read back into the data latch
    wr(OFF_INSTR, 16'h205A);
    wr(OFF_IOREQ, 16'h0003);
    wr(OFF_INSTR, 16'h245A);
    wr(OFF_IOREQ, 16'h0001);
    repeat (3) @(posedge mclk);
    rd(OFF_DATA, {16'h0, acc[0]});
    repeat (4) @(posedge mclk);
    check(strobes, 34'd2);
    final_report();
  end
endmodule : cpu_operand_address_decoder_bench
